//--- design/dis_pkg.sv
// Shared constants, types and state codes for the instruction sequencer.
// Assumes a single converter clock and a host port on the same clock.
package dis_pkg;
  // Host port word addresses
  localparam logic [4:0] ADDR_CFG = 5'h10;
  localparam logic [4:0] ADDR_IEN = 5'h12;
  localparam logic [4:0] ADDR_STAT = 5'h14;
  localparam logic [4:0] ADDR_TMR = 5'h16;
  localparam logic [4:0] ADDR_FIFO = 5'h18;
  // Instruction word fields
  localparam int INS_EXT_LSB = 12;
  localparam int INS_CMP = 11;
  localparam int INS_RES8 = 10;
  localparam int INS_TMR = 9;
  localparam int INS_SYNC = 8;
  localparam int INS_NEG_LSB = 5;
  localparam int INS_POS_LSB = 2;
  localparam int INS_PAUSE = 1;
  localparam int INS_LOOP = 0;
  // Limit word fields
  localparam int LIM_GT = 9;
  localparam int LIM_SIGN = 8;
  // Configuration fields
  localparam int CFG_START = 0;
  localparam int CFG_RESET = 1;
  localparam int CFG_AZ = 2;
  localparam int CFG_FULLCAL = 3;
  localparam int CFG_STANDBY = 4;
  localparam int CFG_CHMASK = 5;
  localparam int CFG_AZ_EACH = 6;
  localparam int CFG_SYNC_DIR = 7;
  localparam int CFG_BANK_LSB = 8;
  // Interrupt enable fields and status bit positions
  localparam int IEN_NUM_LSB = 8;
  localparam int IEN_THR_LSB = 11;
  localparam int IRQ_LIMIT = 0;
  localparam int IRQ_MATCH = 1;
  localparam int IRQ_FIFO = 2;
  localparam int IRQ_ZERO = 3;
  localparam int IRQ_CAL = 4;
  localparam int IRQ_HALT = 5;
  localparam int IRQ_SUPPLY = 6;
  localparam int IRQ_WAKE = 7;
  localparam int RES_NUM_LSB = 13;
  // Reset values
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] IEN_RST = 16'h0000;
  localparam logic [15:0] TMR_RST = 16'h0000;
  // State durations in converter clocks
  localparam logic [20:0] TCK_S0 = 21'h000001;
  localparam logic [20:0] TCK_S1 = 21'h000001;
  localparam logic [20:0] ACQ12_BASE = 21'h000009;
  localparam logic [20:0] ACQ8_BASE = 21'h000002;
  localparam int ACQ_STEP = 2;
  localparam logic [20:0] CONV12 = 21'h00002c;
  localparam logic [20:0] CONV8 = 21'h000015;
  localparam logic [20:0] CMP_S6 = 21'h000005;
  localparam logic [20:0] CMP_S4 = 21'h000001;
  localparam logic [20:0] CMP_S5 = 21'h000005;
  localparam int TMR_UNIT_SHIFT = 5;
  localparam logic [20:0] TMR_OVERHEAD = 21'h000002;
  localparam logic [20:0] CAL_CLKS_DEF = 21'h0004b0;
  localparam logic [20:0] AZ_CLKS_DEF = 21'h000050;
  // Result store
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
  localparam logic [5:0] FIFO_LVL_FULL = 6'h20;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } dis_bus_req_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_FETCH = 9'h002,
    ST_SETUP = 9'h004,
    ST_TIMER = 9'h008,
    ST_ACQ = 9'h010,
    ST_CMP_PRE = 9'h020,
    ST_CMP_MID = 9'h040,
    ST_CONV = 9'h080,
    ST_CAL = 9'h100
  } dis_state_t;
endpackage

//--- design/dis_buf2.sv
// Two-entry valid/ready buffer between the converter and the result store.
// Assumes both sides on clk_sys.
`timescale 1ns/1ps
module dis_buf2 #(
  parameter int W = 16
) (
  input logic clk_sys,
  input logic rst,
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [0:1];
  logic wp_q, rp_q;
  logic [1:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q <= wp_q ^ push;
      rp_q <= rp_q ^ pop;
      if (push & ~pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule // dis_buf2

//--- design/dis_fifo.sv
// Result store with level count, popped by host reads.
// Assumes clr is a one-cycle pulse on clk_sys.
`timescale 1ns/1ps
module dis_fifo (
  input logic clk_sys,
  input logic rst,
  input logic clr,
  input logic in_valid,
  output logic in_ready,
  input logic [15:0] in_data,
  input logic pop,
  output logic [15:0] head,
  output logic [dis_pkg::FIFO_AW:0] count
);
  import dis_pkg::*;
  logic [15:0] mem_q [0:FIFO_DEPTH-1];
  logic [FIFO_AW-1:0] wp_q, rp_q;
  logic [FIFO_AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire do_pop = pop & (cnt_q != 6'h00);
  assign in_ready = (cnt_q != FIFO_LVL_FULL);
  assign head = mem_q[rp_q];
  assign count = cnt_q;
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_q <= 5'h00;
      rp_q <= 5'h00;
      cnt_q <= 6'h00;
    end else if (clr) begin
      wp_q <= 5'h00;
      rp_q <= 5'h00;
      cnt_q <= 6'h00;
    end else begin
      wp_q <= wp_q + 5'(push);
      rp_q <= rp_q + 5'(do_pop);
      if (push & ~do_pop) begin
        cnt_q <= cnt_q + 6'h01;
      end else if (do_pop & ~push) begin
        cnt_q <= cnt_q - 6'h01;
      end
    end
  end
endmodule // dis_fifo

//--- design/dis_instruction_sequencer.sv
// Instruction RAM, sequencer, delay timer, configuration and status logic.
// Assumes the host port and converter data are on clk_sys; sync and supply pins are not.
`timescale 1ns/1ps
//
// Operation
// - Instruction: extension, compare, resolution, timer, sync, minus input, plus input, pause, loop.
// - Instructions run in ascending order from zero without added delay.
// - A loop bit returns the sequencer to instruction zero while running.
// - A timer bit waits the programmed delay before acquisition.
// - Timer delay equals preset times 32 clocks.
// - Timer state adds two fixed clocks.
// - States 0,1 one clock; convert 44 or 21; compare 5,1,5.
// - Acquisition 9 clocks at 12 bits, 2 at 8 bits, plus two per extension.
// - Limit word: greater/less select, sign, eight-bit magnitude.
// - Conversions store one result each; comparisons store none.
// - Level status sets when stored results reach the threshold field.
// - Enable bits gate the eight sources; bits 10..8 hold match number.
// - Configuration: start, reset, zero, calibrate, standby, mask, zero-each, sync, bank, test, diag.
// - With mask clear, results carry the instruction number in bits 15..13.
// - Sync direction bit zero makes the sync pin an input.
// - Start bit zero halts; bank changes only while stopped.
// - Reset command resets the sequencer; calibrate command launches calibration only from idle, and is dropped while running.
// - Reading results leaves the start bit set.
module dis_instruction_sequencer #(
  parameter logic [20:0] CAL_CLKS = dis_pkg::CAL_CLKS_DEF,
  parameter logic [20:0] AZ_CLKS = dis_pkg::AZ_CLKS_DEF
) (
  input logic clk_sys,
  input logic rst,
  input dis_pkg::dis_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  output logic irq_n,
  input logic [12:0] conv_data,
  input logic supply_low,
  input logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic [2:0] positive_input_select,
  output logic [2:0] negative_input_select,
  output logic res8,
  output logic acq_active,
  output logic conv_active,
  output logic cal_active,
  output logic low_power_request
);
  import dis_pkg::*;

  logic [15:0] ram_q [0:31];
  logic [15:0] cfg_q, ien_q, tmr_q, instr_q, lim1_q, lim2_q, rdata_q;
  logic [7:0] stat_q;
  logic [2:0] pc_q;
  logic [20:0] cnt_q, cnt_d;
  logic [20:0] cyc_q;
  dis_state_t state_q, state_d;
  logic [1:0] sup_s_q, syn_s_q;
  logic sup_d1_q, cal_full_q, irq_n_q, sync_out_q, sync_oe_q;
  logic acq_q, conv_q, cal_q;
  logic fin, push_res;

  // Host port decode
  wire wr_ram = bus_req.wr & ~bus_req.addr[4];
  wire wr_cfg = bus_req.wr & (bus_req.addr == ADDR_CFG);
  wire wr_ien = bus_req.wr & (bus_req.addr == ADDR_IEN);
  wire wr_tmr = bus_req.wr & (bus_req.addr == ADDR_TMR);
  wire rd_stat = bus_req.rd & (bus_req.addr == ADDR_STAT);
  wire rd_fifo = bus_req.rd & (bus_req.addr == ADDR_FIFO);
  wire cmd_reset = wr_cfg & bus_req.wdata[CFG_RESET];
  wire cmd_cal = wr_cfg & bus_req.wdata[CFG_FULLCAL];
  wire cmd_az = wr_cfg & bus_req.wdata[CFG_AZ];
  wire run = cfg_q[CFG_START];
  wire [1:0] bank = cfg_q[CFG_BANK_LSB +: 2];
  wire [4:0] host_idx = {bank, bus_req.addr[3:1]};

  // Configuration next value; commands self-clear, bank held while running
  wire [1:0] bank_w = run ? bank : bus_req.wdata[CFG_BANK_LSB +: 2];
  wire start_w = bus_req.wdata[CFG_START] & ~cmd_reset;
  wire halt_w = ~run | (wr_cfg & ~start_w);
  wire [15:0] cfg_w = {bus_req.wdata[15:10], bank_w, bus_req.wdata[7:4], 3'h0, start_w};
  wire pause_stop = fin & instr_q[INS_PAUSE];
  wire [15:0] cfg_d = wr_cfg ? cfg_w : {cfg_q[15:1], run & ~pause_stop};

  // Instruction decode
  wire [3:0] ext = instr_q[INS_EXT_LSB +: 4];
  wire is_cmp = instr_q[INS_CMP];
  wire is_res8 = instr_q[INS_RES8];
  wire narrow = is_res8 | is_cmp;
  wire [20:0] acq_len = (narrow ? ACQ8_BASE : ACQ12_BASE) + 21'(ACQ_STEP * ext);
  wire [20:0] tmr_len = (21'(tmr_q) << TMR_UNIT_SHIFT) + TMR_OVERHEAD;
  wire [20:0] conv_len = is_cmp ? CMP_S5 : (is_res8 ? CONV8 : CONV12);
  wire done = (cnt_q == 21'h000000);
  wire sync_ok = ~instr_q[INS_SYNC] | cfg_q[CFG_SYNC_DIR] | syn_s_q[1];

  // Limit comparison on the 8-bit plus sign value
  wire signed [8:0] val9 = conv_data[12:4];
  wire signed [8:0] l1 = {lim1_q[LIM_SIGN], lim1_q[7:0]};
  wire signed [8:0] l2 = {lim2_q[LIM_SIGN], lim2_q[7:0]};
  wire hit1 = lim1_q[LIM_GT] ? (val9 > l1) : (val9 < l1);
  wire hit2 = lim2_q[LIM_GT] ? (val9 > l2) : (val9 < l2);
  wire limit_ev = fin & is_cmp & (hit1 | hit2);

  // Result word and buffering
  wire [15:0] res_word = cfg_q[CFG_CHMASK] ? {{3{conv_data[12]}}, conv_data} : {pc_q, conv_data};
  wire buf_ready, fifo_valid, fifo_ready;
  wire [15:0] fifo_in, fifo_head;
  wire [5:0] fifo_count;

  dis_buf2 #(.W(16)) u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(push_res),
    .in_ready(buf_ready),
    .in_data(res_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_in)
  );

  dis_fifo u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(cmd_reset),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data(fifo_in),
    .pop(rd_fifo),
    .head(fifo_head),
    .count(fifo_count)
  );

  // Status sources
  wire [4:0] thr = ien_q[IEN_THR_LSB +: 5];
  wire cal_end = (state_q == ST_CAL) & done;
  wire [7:0] stat_set;
  assign stat_set[IRQ_LIMIT] = limit_ev;
  assign stat_set[IRQ_MATCH] = fin & (pc_q == ien_q[IEN_NUM_LSB +: 3]);
  assign stat_set[IRQ_FIFO] = (fifo_count >= {1'b0, thr});
  assign stat_set[IRQ_ZERO] = cal_end & ~cal_full_q;
  assign stat_set[IRQ_CAL] = cal_end & cal_full_q;
  assign stat_set[IRQ_HALT] = pause_stop;
  assign stat_set[IRQ_SUPPLY] = sup_s_q[1] & ~sup_d1_q;
  assign stat_set[IRQ_WAKE] = wr_cfg & cfg_q[CFG_STANDBY] & ~bus_req.wdata[CFG_STANDBY];
  wire [7:0] stat_clr = rd_stat ? 8'hff : 8'h00;
  wire [7:0] stat_d = (stat_q & ~stat_clr) | stat_set;

  // Read selection
  wire [15:0] rd_mux = ~bus_req.addr[4] ? ram_q[host_idx] :
                       (bus_req.addr == ADDR_CFG) ? cfg_q :
                       (bus_req.addr == ADDR_IEN) ? ien_q :
                       (bus_req.addr == ADDR_STAT) ? {2'h0, fifo_count, stat_q} :
                       (bus_req.addr == ADDR_TMR) ? tmr_q :
                       (bus_req.addr == ADDR_FIFO) ? fifo_head : 16'h0000;

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d = done ? cnt_q : cnt_q - 21'h000001;
    fin = 1'b0;
    push_res = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (cmd_cal | cmd_az) begin
          state_d = ST_CAL;
          cnt_d = (cmd_cal ? CAL_CLKS : AZ_CLKS) - 21'h000001;
        end else if (~halt_w) begin
          state_d = ST_FETCH;
          cnt_d = TCK_S0 - 21'h000001;
        end
      end
      ST_FETCH: begin
        if (done) begin
          state_d = ST_SETUP;
          cnt_d = TCK_S1 - 21'h000001;
        end
      end
      ST_SETUP: begin
        if (done & sync_ok) begin
          if (instr_q[INS_TMR]) begin
            state_d = ST_TIMER;
            cnt_d = tmr_len - 21'h000001;
          end else begin
            state_d = ST_ACQ;
            cnt_d = acq_len - 21'h000001;
          end
        end
      end
      ST_TIMER: begin
        if (done) begin
          state_d = ST_ACQ;
          cnt_d = acq_len - 21'h000001;
        end
      end
      ST_ACQ: begin
        if (done) begin
          state_d = is_cmp ? ST_CMP_PRE : ST_CONV;
          cnt_d = (is_cmp ? CMP_S6 : conv_len) - 21'h000001;
        end
      end
      ST_CMP_PRE: begin
        if (done) begin
          state_d = ST_CMP_MID;
          cnt_d = CMP_S4 - 21'h000001;
        end
      end
      ST_CMP_MID: begin
        if (done) begin
          state_d = ST_CONV;
          cnt_d = conv_len - 21'h000001;
        end
      end
      ST_CONV: begin
        if (done & (is_cmp | buf_ready)) begin
          fin = 1'b1;
          push_res = ~is_cmp;
          state_d = instr_q[INS_PAUSE] ? ST_IDLE : ST_FETCH;
          cnt_d = TCK_S0 - 21'h000001;
        end
      end
      ST_CAL: begin
        if (done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (halt_w & (state_q != ST_IDLE) & (state_q != ST_CAL)) begin
      state_d = ST_IDLE;
      fin = 1'b0;
      push_res = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_ram) begin
      ram_q[host_idx] <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 21'h000000;
      cyc_q <= 21'h000000;
      pc_q <= 3'h0;
      cfg_q <= CFG_RST;
      ien_q <= IEN_RST;
      tmr_q <= TMR_RST;
      stat_q <= 8'h00;
      cal_full_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cyc_q <= (state_d != state_q) ? 21'h000000 : cyc_q + 21'h000001;
      cfg_q <= cfg_d;
      stat_q <= stat_d;
      if (wr_ien) begin
        ien_q <= bus_req.wdata;
      end
      if (wr_tmr) begin
        tmr_q <= bus_req.wdata;
      end
      if (cmd_reset | (state_d == ST_IDLE & halt_w & state_q != ST_IDLE & ~pause_stop)) begin
        pc_q <= 3'h0;
      end else if (fin) begin
        pc_q <= instr_q[INS_LOOP] ? 3'h0 : pc_q + 3'h1;
      end
      if (state_q == ST_IDLE & (cmd_cal | cmd_az)) begin
        cal_full_q <= cmd_cal;
      end
    end
  end

  // Instruction and limit fetch in state 0
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      instr_q <= 16'h0000;
      lim1_q <= 16'h0000;
      lim2_q <= 16'h0000;
    end else if (state_q == ST_FETCH) begin
      instr_q <= ram_q[{2'h0, pc_q}];
      lim1_q <= ram_q[{2'h1, pc_q}];
      lim2_q <= ram_q[{2'h2, pc_q}];
    end
  end

  // Pin synchronisers and registered outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sup_s_q <= 2'h0;
      syn_s_q <= 2'h0;
      sup_d1_q <= 1'b0;
      rdata_q <= 16'h0000;
      irq_n_q <= 1'b1;
      sync_out_q <= 1'b0;
      sync_oe_q <= 1'b0;
      acq_q <= 1'b0;
      conv_q <= 1'b0;
      cal_q <= 1'b0;
    end else begin
      sup_s_q <= {sup_s_q[0], supply_low};
      syn_s_q <= {syn_s_q[0], sync_in};
      sup_d1_q <= sup_s_q[1];
      if (bus_req.rd) begin
        rdata_q <= rd_mux;
      end
      irq_n_q <= ~|(stat_d & ien_q[7:0]);
      sync_out_q <= (state_d == ST_SETUP);
      sync_oe_q <= cfg_d[CFG_SYNC_DIR];
      acq_q <= (state_d == ST_ACQ);
      conv_q <= (state_d == ST_CONV) | (state_d == ST_CMP_PRE) | (state_d == ST_CMP_MID);
      cal_q <= (state_d == ST_CAL);
    end
  end

  assign bus_rdata = rdata_q;
  assign irq_n = irq_n_q;
  assign sync_out = sync_out_q;
  assign sync_oe = sync_oe_q;
  assign positive_input_select = instr_q[INS_POS_LSB +: 3];
  assign negative_input_select = instr_q[INS_NEG_LSB +: 3];
  assign res8 = instr_q[INS_RES8];
  assign acq_active = acq_q;
  assign conv_active = conv_q;
  assign cal_active = cal_q;
  assign low_power_request = cfg_q[CFG_STANDBY];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_FETCH_ONE: assert property (state_q == ST_FETCH |=> state_q != ST_FETCH)
    else $error("state 0 lasted more than one clock");
  AST_ACQ_LEN: assert property ((state_q == ST_ACQ) && (state_d != ST_ACQ) && !halt_w
    |-> cyc_q == acq_len - 21'h000001)
    else $error("acquisition length wrong");
  AST_TMR_LEN: assert property ((state_q == ST_TIMER) && (state_d == ST_ACQ)
    |-> cyc_q == tmr_len - 21'h000001)
    else $error("timer length wrong");
  AST_CONV_LEN: assert property ((state_q == ST_CONV) && fin |-> cyc_q >= conv_len - 21'h000001)
    else $error("conversion ended early");
  AST_CMP_LEN: assert property ($rose(state_q == ST_CMP_PRE) |-> (state_q == ST_CMP_PRE) [*5] ##1
    (state_q == ST_CMP_MID || state_q == ST_IDLE))
    else $error("compare state 6 length wrong");
  AST_LOOP: assert property (fin && instr_q[INS_LOOP] && !cmd_reset |=> pc_q == 3'h0)
    else $error("loop did not return to zero");
  AST_ASCEND: assert property (fin && !instr_q[INS_LOOP] && !cmd_reset |=> pc_q == $past(pc_q) + 3'h1)
    else $error("instruction order broken");
  AST_NO_CMP_PUSH: assert property (push_res |-> state_q == ST_CONV && !instr_q[INS_CMP])
    else $error("comparison stored a result");
  AST_STOP: assert property (wr_cfg && !bus_req.wdata[CFG_START] |=>
    state_q == ST_IDLE || state_q == ST_CAL)
    else $error("sequencer did not halt");
  AST_LEVEL: assert property (fifo_count >= {1'b0, thr} |=> stat_q[IRQ_FIFO])
    else $error("level status missing");
  AST_IRQ: assert property (|(stat_q & ien_q[7:0]) && !rd_stat |=> !irq_n)
    else $error("enabled status did not assert interrupt");
  AST_SYNC_IN: assert property (wr_cfg && !bus_req.wdata[CFG_SYNC_DIR] |=> !sync_oe)
    else $error("sync pin driven in input mode");
  AST_FIFO_RUN: assert property (rd_fifo && run && !wr_cfg && !pause_stop |=> run)
    else $error("result read cleared start");
  AST_LIMIT: assert property (limit_ev |=> stat_q[IRQ_LIMIT])
    else $error("limit status missing");
  AST_CAL: assert property (cmd_cal && state_q == ST_IDLE |=> state_q == ST_CAL ##0 cal_full_q)
    else $error("calibration not launched");

  COV_LOOP: cover property (fin && instr_q[INS_LOOP]);
  COV_CMP: cover property (fin && is_cmp);
  COV_TIMER: cover property (state_q == ST_TIMER ##1 state_q == ST_ACQ);
  COV_STALL: cover property (state_q == ST_CONV && done && !buf_ready);
endmodule // dis_instruction_sequencer

//--- dv/dis_host_model.sv
// Host model: single-word writes and reads on the sequencer register port.
// Assumes requests are sampled on the rising edge of clk_sys.
`timescale 1ns/1ps
module dis_host_model (
  input wire logic clk_sys,
  output dis_pkg::dis_bus_req_t bus_req,
  input wire logic [15:0] bus_rdata
);
  import dis_pkg::*;
  initial bus_req = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    bus_req.wr = 1'b1;
    bus_req.addr = a;
    bus_req.wdata = d;
    @(posedge clk_sys);
    #1;
    bus_req.wr = 1'b0;
    bus_req.wdata = ~d;
  endtask
  // Whole 16-bit words, so the low result byte is never lost
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    #1;
    bus_req.rd = 1'b1;
    bus_req.addr = a;
    @(posedge clk_sys);
    #1;
    bus_req.rd = 1'b0;
    bus_req.addr = ~a;
    d = bus_rdata;
  endtask
  // Bank select written with start clear
  task automatic set_bank(input logic [1:0] b);
    wr(ADDR_CFG, {6'h00, b, 8'h00});
  endtask
endmodule // dis_host_model

//--- dv/testbench.sv
// Testbench: register rows, then a three-instruction looping program.
// Assumes the host model drives the bus; the bench drives converter data and pins.
`timescale 1ns/1ps
module testbench;
  import dis_pkg::*;
  typedef struct packed {
    logic [4:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } dis_row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  dis_bus_req_t bus_req;
  logic [15:0] bus_rdata;
  logic [15:0] rv;
  logic [12:0] conv_data = 13'h0ff0;
  logic supply_low = 1'b0;
  logic sync_in = 1'b0;
  logic irq_n, sync_out, sync_oe, res8, acq_active, conv_active, cal_active, low_power_request;
  logic [2:0] pos_sel, neg_sel;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int acq_n = 0;
  int conv_n = 0;
  int gap_n = 0;
  int k;
  int aq[$], cq[$], gq[$];
  dis_row_t rows[5] = '{'{5'h0e, 16'h0211, 16'h0211}, '{ADDR_TMR, 16'h1380, 16'h1380},
    '{ADDR_IEN, 16'hf015, 16'hf015}, '{5'h1a, 16'h1234, 16'h0000}, '{ADDR_CFG, 16'h0080, 16'h0080}};

  dis_host_model host_i (.clk_sys(clk_sys), .bus_req(bus_req), .bus_rdata(bus_rdata));
  dis_instruction_sequencer #(.CAL_CLKS(21'h000008), .AZ_CLKS(21'h000008)) dis_instruction_sequencer_i (
    .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata), .irq_n(irq_n),
    .conv_data(conv_data), .supply_low(supply_low), .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
    .positive_input_select(pos_sel), .negative_input_select(neg_sel), .res8(res8),
    .acq_active(acq_active), .conv_active(conv_active), .cal_active(cal_active),
    .low_power_request(low_power_request));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // Run lengths of the acquisition and conversion levels, idle gaps before acquisition
  always @(posedge clk_sys) begin
    if (acq_active) acq_n++;
    else if (acq_n != 0) begin
      aq.push_back(acq_n);
      acq_n = 0;
    end
    if (conv_active) conv_n++;
    else if (conv_n != 0) begin
      cq.push_back(conv_n);
      conv_n = 0;
    end
    if (!acq_active && !conv_active) gap_n++;
    else begin
      if (acq_active && gap_n != 0) gq.push_back(gap_n);
      gap_n = 0;
    end
  end

  initial begin
    #20;
    check(bus_rdata, 16'h0000);
    check({15'h0000, irq_n}, 16'h0001);
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    foreach (rows[i]) begin
      host_i.wr(rows[i].a, rows[i].d);
      host_i.rd(rows[i].a, rv);
      check(rv, rows[i].e);
    end
    check({15'h0000, sync_oe}, 16'h0001);
    host_i.wr(ADDR_CFG, 16'h0000);
    check({15'h0000, sync_oe}, 16'h0000);
    host_i.set_bank(2'h1);
    host_i.wr(5'h04, 16'h0210);
    host_i.set_bank(2'h2);
    host_i.wr(5'h04, 16'h0100); // Unused limit at negative full scale
    host_i.set_bank(2'h0);
    host_i.wr(5'h00, 16'h0200);
    host_i.wr(5'h02, 16'h240c); // Extension 2 for a slow source
    host_i.wr(5'h04, 16'h280d);
    host_i.wr(ADDR_TMR, 16'h0002);
    host_i.wr(ADDR_IEN, 16'h1005);
    host_i.wr(ADDR_CFG, 16'h0001);
    k = 0;
    while (gq.size() < 4 && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
    check(16'(aq[0]), 16'h0009);
    check(16'(aq[1]), 16'h0006);
    check(16'(aq[2]), 16'h0006);
    check(16'(cq[0]), 16'h002c);
    check(16'(cq[1]), 16'h0015);
    check(16'(cq[2]), 16'h000b);
    check(16'(gq[1]), 16'h0002);
    check(16'(gq[2]), 16'h0002);
    check(16'(gq[3]), 16'h0044);
    host_i.rd(ADDR_FIFO, rv);
    check(rv, 16'h0ff0);
    host_i.rd(ADDR_CFG, rv);
    check(rv, 16'h0001);
    host_i.wr(ADDR_CFG, 16'h0000);
    repeat (100) @(posedge clk_sys);
    #1;
    check({14'h0000, acq_active, conv_active}, 16'h0000);
    check({15'h0000, irq_n}, 16'h0000);
    host_i.rd(ADDR_STAT, rv);
    check(rv & 16'h0005, 16'h0005);
    host_i.rd(ADDR_FIFO, rv);
    check(rv, 16'h2ff0);
    host_i.wr(ADDR_CFG, 16'h0002);
    host_i.rd(ADDR_CFG, rv);
    check(rv, 16'h0000);
    host_i.rd(ADDR_STAT, rv);
    check(rv & 16'h3f00, 16'h0000);
    host_i.wr(ADDR_CFG, 16'h0008);
    k = 0;
    while (cal_active !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      k++;
    end
    check({15'h0000, cal_active}, 16'h0001);
    while (cal_active === 1'b1 && k < 60) begin
      @(posedge clk_sys);
      k++;
    end
    host_i.rd(ADDR_STAT, rv);
    check(rv & 16'h0010, 16'h0010);
    // Supply pin edge and return from standby
    supply_low = 1'b1;
    host_i.wr(ADDR_CFG, 16'h0010);
    check({15'h0000, low_power_request}, 16'h0001);
    host_i.wr(ADDR_CFG, 16'h0000);
    host_i.rd(ADDR_STAT, rv);
    check(rv & 16'h00c0, 16'h00c0);
    supply_low = 1'b0;
    // Sync wait on an input sync pin, then a new converter value
    conv_data = 13'h1abc;
    host_i.wr(5'h00, 16'h0150);
    host_i.wr(ADDR_CFG, 16'h0001);
    repeat (10) @(posedge clk_sys);
    #1;
    check({8'h00, neg_sel, sync_out, acq_active, pos_sel}, 16'h0054);
    sync_in = 1'b1;
    k = 0;
    while (acq_active !== 1'b1 && k < 10) begin
      @(posedge clk_sys);
      k++;
    end
    #1;
    check({15'h0000, acq_active}, 16'h0001);
    repeat (60) @(posedge clk_sys);
    #1;
    check({15'h0000, res8}, 16'h0001);
    host_i.wr(ADDR_CFG, 16'h0000);
    host_i.rd(ADDR_FIFO, rv);
    check(rv, 16'h1abc);
    report_and_stop();
  end
endmodule // testbench
